// ### verilog/fpme_pkg.sv
/*
  Constants and carrier types for the flash program mode entry block.
  Assumes one system clock of 125 MHz and a link clock from the programmer.
*/
// Function
// - High programming voltage gates programming mode entry
// - Pulse count 0/1/8 picks link
// - Three-wire serial clock within supported rate window; only rates above the window are flagged
// - Asynchronous bit rate within supported window; nothing here checks it, only the package constants give it
// - Unused pins keep their after-reset state
package fpme_pkg;
  // Link selection codes
  typedef enum logic [1:0] {
    FPME_LINK_NONE = 2'b00,
    FPME_LINK_A = 2'b01,
    FPME_LINK_B = 2'b10,
    FPME_LINK_ASYNC = 2'b11
  } fpme_link_t;
  // Pulse counts that select each link
  localparam logic [3:0] FPME_PULSES_A = 4'h0;
  localparam logic [3:0] FPME_PULSES_B = 4'h1;
  localparam logic [3:0] FPME_PULSES_ASYNC = 4'h8;
  localparam logic [3:0] FPME_PULSES_MAX = 4'hf;
  // Timing: window after voltage rise in which pulses are counted
  localparam int FPME_CLK_MHZ = 125;
  localparam int FPME_PULSE_WINDOW_US = 100;
  localparam int FPME_PULSE_WINDOW_CYC = FPME_PULSE_WINDOW_US * FPME_CLK_MHZ;
  // Three-wire clock window: 100 Hz .. 1.25 MHz
  localparam int FPME_SCLK_MIN_HZ = 100;
  localparam int FPME_SCLK_MAX_HZ = 1250000;
  // Shortest legal half period in system cycles, rounded down
  localparam int FPME_SCLK_HALF_MIN_CYC = (FPME_CLK_MHZ * 1000000) / (2 * FPME_SCLK_MAX_HZ);
  // Asynchronous bit rates 4800 .. 76800 bps
  localparam int FPME_BAUD_MIN = 4800;
  localparam int FPME_BAUD_MAX = 76800;
  localparam int FPME_BIT_MIN_CYC = (FPME_CLK_MHZ * 1000000) / FPME_BAUD_MAX;
  localparam int FPME_BIT_MAX_CYC = (FPME_CLK_MHZ * 1000000 + FPME_BAUD_MIN - 1) / FPME_BAUD_MIN;
  // Reset state of unused pins: input, not driven
  localparam logic FPME_PIN_RESET_OE = 1'b0;
  localparam logic FPME_PIN_RESET_OUT = 1'b0;
  // Status seen by the flash core
  typedef struct packed {
    logic prog_mode;
    fpme_link_t link;
    logic rate_error;
  } fpme_status_t;
  // Byte moving between link and core
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } fpme_byte_t;
endpackage

// ### verilog/fpme_sync.sv
/*
  Two flip-flop synchroniser for one level.
  Assumes the input is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module fpme_sync (
  input wire logic clk,
  input wire logic resetn,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1; // First stage, read only by stage two
  logic next_stage1;
  logic next_sync_out;

  // Next values
  always_comb begin
    next_stage1 = async_in;
    next_sync_out = stage1;
  end

  // Registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage1 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      stage1 <= next_stage1;
      sync_out <= next_sync_out;
    end
  end
endmodule
`default_nettype wire

// ### verilog/fpme_top.sv
/*
  Programming mode entry: watches the programming voltage, counts its
  pulses, picks a link, and shifts bytes on the three-wire links.
  Assumes a programmer that owns reset and supply, and sources the
  three-wire clock; asynchronous link bytes are handled by a core UART.
*/
`timescale 1ns/1ps
`default_nettype none
module fpme_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic vpp_high,
  input wire logic link_clk,
  input wire logic sync_serial_in_pin,
  input wire logic port0_bit2,
  output logic sync_serial_out_pin,
  output logic sync_serial_out_oe,
  output logic port0_bit1,
  output logic port0_bit1_oe,
  output logic async_tx_oe,
  output logic other_pins_oe,
  output fpme_pkg::fpme_status_t status,
  output fpme_pkg::fpme_byte_t rx_byte,
  input wire logic [7:0] tx_data
);
  // Entry sequencer states
  typedef enum logic [1:0] {
    FPME_ST_IDLE = 2'b00,
    FPME_ST_COUNT = 2'b01,
    FPME_ST_PROG = 2'b10
  } fpme_state_t;

  logic vpp_s; // Synchronised programming voltage
  logic vpp_d; // Previous sample for edges
  fpme_state_t state;
  fpme_state_t next_state;
  logic [3:0] pulses; // Pulse count
  logic [3:0] next_pulses;
  logic [13:0] win; // Counting window timer
  logic [13:0] next_win;
  fpme_pkg::fpme_link_t link;
  fpme_pkg::fpme_link_t next_link;

  fpme_sync u_vpp_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(vpp_high),
    .sync_out(vpp_s)
  );

  // Entry sequencer next state
  always_comb begin
    next_state = state;
    next_pulses = pulses;
    next_win = win;
    next_link = link;
    case (state)
      FPME_ST_IDLE: begin
        // A steady high voltage starts the pulse window
        if (vpp_s && vpp_d) begin
          next_state = FPME_ST_COUNT;
          next_pulses = 4'h0;
          next_win = 14'h0;
        end
      end
      FPME_ST_COUNT: begin
        // Each falling then rising cycle of the voltage counts one pulse
        if (vpp_s && !vpp_d && pulses != fpme_pkg::FPME_PULSES_MAX) begin
          next_pulses = pulses + 4'h1;
          next_win = 14'h0;
        end else begin
          next_win = win + 14'h1;
        end
        if (win == 14'(fpme_pkg::FPME_PULSE_WINDOW_CYC - 1) && vpp_s) begin
          next_state = FPME_ST_PROG;
          // Unknown counts leave no link rather than guess one
          case (pulses)
            fpme_pkg::FPME_PULSES_A: next_link = fpme_pkg::FPME_LINK_A;
            fpme_pkg::FPME_PULSES_B: next_link = fpme_pkg::FPME_LINK_B;
            fpme_pkg::FPME_PULSES_ASYNC: next_link = fpme_pkg::FPME_LINK_ASYNC;
            default: next_link = fpme_pkg::FPME_LINK_NONE;
          endcase
        end
      end
      FPME_ST_PROG: begin
        // Voltage must stay high throughout writing and verify
        if (!vpp_s) begin
          next_state = FPME_ST_IDLE;
          next_link = fpme_pkg::FPME_LINK_NONE;
        end
      end
      default: begin
        next_state = FPME_ST_IDLE;
        next_link = fpme_pkg::FPME_LINK_NONE;
      end
    endcase
  end

  // Entry sequencer registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= FPME_ST_IDLE;
      pulses <= 4'h0;
      win <= 14'h0;
      link <= fpme_pkg::FPME_LINK_NONE;
      vpp_d <= 1'b0;
    end else begin
      state <= next_state;
      pulses <= next_pulses;
      win <= next_win;
      link <= next_link;
      vpp_d <= vpp_s;
    end
  end

  logic prog_mode; // Programming mode active
  assign prog_mode = (state == FPME_ST_PROG);

  // Level crossing of the selected link into the link domain
  logic sel_a_raw;
  logic sel_b_raw;
  logic sel_a_l; // Channel A selected, link domain
  logic sel_b_l; // Channel B selected, link domain
  assign sel_a_raw = prog_mode && link == fpme_pkg::FPME_LINK_A;
  assign sel_b_raw = prog_mode && link == fpme_pkg::FPME_LINK_B;

  // Cleared at once on deselect: the link clock is stopped by then, so only
  // an async clear drops the enables; the two setting edges also zero bitn
  fpme_sync u_sel_a_sync (
    .clk(link_clk),
    .resetn(resetn && sel_a_raw),
    .async_in(sel_a_raw),
    .sync_out(sel_a_l)
  );
  fpme_sync u_sel_b_sync (
    .clk(link_clk),
    .resetn(resetn && sel_b_raw),
    .async_in(sel_b_raw),
    .sync_out(sel_b_l)
  );

  // Link domain shifter, clocked by the programmer's serial clock
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [2:0] bitn;
  logic [2:0] next_bitn;
  logic [7:0] rx_hold; // Held byte, stable while toggle crosses
  logic [7:0] next_rx_hold;
  logic rx_tog;
  logic next_rx_tog;
  logic din; // Data in from the selected pin

  // Pin routing per link
  assign din = sel_b_l ? port0_bit2 : sync_serial_in_pin;

  // Shifter next values; the first bit loads the transmit byte
  always_comb begin
    next_shift = shift;
    next_bitn = bitn;
    next_rx_hold = rx_hold;
    next_rx_tog = rx_tog;
    if (sel_a_l || sel_b_l) begin
      if (bitn == 3'h0) begin
        next_shift = {tx_data[6:0], din};
      end else begin
        next_shift = {shift[6:0], din};
      end
      next_bitn = bitn + 3'h1;
      if (bitn == 3'h7) begin
        next_rx_hold = {shift[6:0], din};
        next_rx_tog = ~rx_tog;
      end
    end else begin
      next_bitn = 3'h0;
    end
  end

  // Shifter registers
  always_ff @(posedge link_clk or negedge resetn) begin
    if (!resetn) begin
      shift <= 8'h00;
      bitn <= 3'h0;
      rx_hold <= 8'h00;
      rx_tog <= 1'b0;
    end else begin
      shift <= next_shift;
      bitn <= next_bitn;
      rx_hold <= next_rx_hold;
      rx_tog <= next_rx_tog;
    end
  end

  // Outgoing bit: MSB first, tx byte top bit at bit zero
  logic dout;
  assign dout = (bitn == 3'h0) ? tx_data[7] : shift[7];

  // Byte event crossing back to clk via toggle
  logic tog_s;
  logic tog_d;
  fpme_sync u_tog_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(rx_tog),
    .sync_out(tog_s)
  );

  fpme_pkg::fpme_byte_t next_rx_byte;
  // Captured byte; rx_hold is stable for many link edges past the toggle
  always_comb begin
    next_rx_byte.valid = tog_s ^ tog_d;
    next_rx_byte.data = (tog_s ^ tog_d) ? rx_hold : rx_byte.data;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tog_d <= 1'b0;
      rx_byte <= '0;
    end else begin
      tog_d <= tog_s;
      rx_byte <= next_rx_byte;
    end
  end

  // Pin drives; every other pin keeps its reset state
  always_comb begin
    sync_serial_out_pin = dout;
    sync_serial_out_oe = sel_a_l;
    port0_bit1 = dout;
    port0_bit1_oe = sel_b_l;
    async_tx_oe = prog_mode && link == fpme_pkg::FPME_LINK_ASYNC;
    other_pins_oe = fpme_pkg::FPME_PIN_RESET_OE;
  end

  // Serial clock rate watch in the clk domain; rates above the window are flagged
  logic sck_s;
  logic sck_d;
  logic [7:0] half; // Cycles since last link clock edge
  logic [7:0] next_half;
  logic rate_err;
  logic next_rate_err;
  fpme_sync u_sck_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(link_clk),
    .sync_out(sck_s)
  );

  always_comb begin
    next_half = (sck_s != sck_d) ? 8'h00 : (half == 8'hff ? half : half + 8'h01);
    next_rate_err = rate_err;
    if (!prog_mode) begin
      next_rate_err = 1'b0;
    end else if (sck_s != sck_d && half < 8'(fpme_pkg::FPME_SCLK_HALF_MIN_CYC - 2)) begin
      next_rate_err = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sck_d <= 1'b0;
      half <= 8'h00;
      rate_err <= 1'b0;
    end else begin
      sck_d <= sck_s;
      half <= next_half;
      rate_err <= next_rate_err;
    end
  end

  assign status = '{prog_mode: prog_mode, link: link, rate_error: rate_err};

  // Leaving on voltage loss
  prog_exit_a: assert property (@(posedge clk) disable iff (!resetn)
    prog_mode && !vpp_s |=> !prog_mode)
    else $error("programming mode held without voltage");
  // Link decode at window end
  sequence win_end_s;
    state == FPME_ST_COUNT && win == 14'(fpme_pkg::FPME_PULSE_WINDOW_CYC - 1) && vpp_s;
  endsequence
  link_decode_a: assert property (@(posedge clk) disable iff (!resetn)
    win_end_s and pulses == 4'h1 |=> link == fpme_pkg::FPME_LINK_B && prog_mode)
    else $error("one pulse did not pick channel b");
  unused_pins_a: assert property (@(posedge clk) disable iff (!resetn)
    other_pins_oe == 1'b0)
    else $error("unused pin driven");
  pin_route_a: assert property (@(posedge link_clk) disable iff (!resetn)
    !(sync_serial_out_oe && port0_bit1_oe))
    else $error("two links drive at once");
  link_oe_off_a: assert property (@(posedge clk) disable iff (!resetn)
    !prog_mode |-> !sync_serial_out_oe && !port0_bit1_oe)
    else $error("link pin driven outside programming mode");
  async_pick_a: assert property (@(posedge clk) disable iff (!resetn)
    win_end_s ##0 pulses == fpme_pkg::FPME_PULSES_ASYNC |=> async_tx_oe)
    else $error("eight pulses did not pick the async link");
endmodule
`default_nettype wire

// ### verification/fpme_prog_model.sv
/*
  Behavioural model of the flash programmer at the far side of the link.
  Assumes the bench calls its tasks and that clk is the device clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fpme_prog_model (
  input wire logic clk,
  output logic vpp_high,
  output logic link_clk,
  output logic din_a,
  output logic din_b,
  input wire logic dout_a,
  input wire logic dout_b
);
  // Supply is taken as present from time zero
  // No oscillator drive: a resonator clocks the device
  initial begin
    vpp_high = 1'b0;
    link_clk = 1'b0;
    din_a = 1'b1;
    din_b = 1'b0;
  end
  // High voltage, then n low-high pulses on it
  task automatic enter(input int n);
    @(negedge clk);
    vpp_high = 1'b1;
    repeat (n) begin
      repeat (20) @(negedge clk);
      vpp_high = 1'b0;
      repeat (20) @(negedge clk);
      vpp_high = 1'b1;
    end
  endtask
  // Drop the high voltage to leave programming
  task automatic leave();
    @(negedge clk);
    vpp_high = 1'b0;
  endtask
  // Two enable edges, then one byte MSB first; clock idles low between frames
  task automatic xfer(input logic ch_b, input logic [7:0] tx, input realtime half,
                      output logic [7:0] rx);
    for (int i = 0; i < 10; i++) begin
      // Preamble bits invert the line so no stale value shows
      din_a = (i < 2) ? ~din_a : tx[9 - i];
      din_b = (i < 2) ? ~din_b : tx[9 - i];
      #half;
      // The device shows each bit before the edge that takes it
      if (i >= 2) begin
        rx[9 - i] = ch_b ? dout_b : dout_a;
      end
      link_clk = 1'b1;
      #half link_clk = 1'b0;
    end
    // Released lines show the inverse of the last bit
    din_a = ~din_a;
    din_b = ~din_b;
  endtask
endmodule
`default_nettype wire

// ### verification/test_flash_program_mode_entry.sv
/*
  Self-checking bench for the programming mode entry block.
  Assumes fpme_prog_model as programmer and the package window length.
*/
`timescale 1ns/1ps
`default_nettype none
module test_flash_program_mode_entry;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic vpp_high, link_clk, din_a, din_b, dout_a, oe_a, dout_b, oe_b, tx_oe, other_oe;
  logic [7:0] tx_data = 8'h00;
  logic [7:0] rx;
  fpme_pkg::fpme_status_t status;
  fpme_pkg::fpme_byte_t rx_byte;
  int mismatches = 0;
  int check_count = 0;
  int n;
  // One row: pulse count, link it picks, bytes each way
  typedef struct {
    int pulses;
    fpme_pkg::fpme_link_t link;
    logic [7:0] tx;
    logic [7:0] rx;
  } fpme_row_t;
  fpme_row_t rows[4] = '{'{0, fpme_pkg::FPME_LINK_A, 8'ha5, 8'h3c},
                         '{1, fpme_pkg::FPME_LINK_B, 8'h81, 8'h7e},
                         '{8, fpme_pkg::FPME_LINK_ASYNC, 8'h00, 8'h00},
                         '{3, fpme_pkg::FPME_LINK_NONE, 8'h00, 8'h00}};
  always #4 clk = ~clk;
  fpme_top i_dut (
    .clk(clk), .resetn(resetn), .vpp_high(vpp_high), .link_clk(link_clk),
    .sync_serial_in_pin(din_a), .port0_bit2(din_b), .sync_serial_out_pin(dout_a),
    .sync_serial_out_oe(oe_a), .port0_bit1(dout_b), .port0_bit1_oe(oe_b),
    .async_tx_oe(tx_oe), .other_pins_oe(other_oe), .status(status),
    .rx_byte(rx_byte), .tx_data(tx_data)
  );
  fpme_prog_model i_prog (
    .clk(clk), .vpp_high(vpp_high), .link_clk(link_clk), .din_a(din_a),
    .din_b(din_b), .dout_a(dout_a), .dout_b(dout_b)
  );
  // Counts and verdict in one place
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask
  // Bounded wait on the mode flag; a hang ends the run
  task automatic wait_mode(input logic want);
    for (n = 0; n < 20000 && status.prog_mode !== want; n++) @(negedge clk);
    check("prog mode", {7'h00, want}, {7'h00, status.prog_mode});
    if (n == 20000) finish_test();
  endtask
  // One byte each way at a legal rate, watching the single-cycle valid
  task automatic run_byte(input logic ch_b, input logic [7:0] tx, input logic [7:0] rxv);
    logic seen;
    seen = 1'b0;
    tx_data = tx;
    fork
      i_prog.xfer(ch_b, rxv, 500.0, rx);
      for (int k = 0; k < 20000 && !seen; k++) begin
        @(posedge clk);
        #1 seen = (rx_byte.valid === 1'b1);
        if (seen) check("rx byte", rxv, rx_byte.data);
      end
    join
    check("rx valid", 8'h01, {7'h00, seen});
    if (!seen) finish_test();
    check("tx byte", tx, rx);
    check("rate error", 8'h00, {7'h00, status.rate_error});
  endtask
  initial begin
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    check("reset status", 8'h00, {4'h0, status});
    // Every selection count, plus a refused one
    for (int r = 0; r < 4; r++) begin
      i_prog.enter(rows[r].pulses);
      wait_mode(1'b1);
      check("link", {6'h00, rows[r].link}, {6'h00, status.link});
      check("tx oe", {7'h00, rows[r].link == fpme_pkg::FPME_LINK_ASYNC}, {7'h00, tx_oe});
      check("other oe", 8'h00, {7'h00, other_oe});
      if (rows[r].pulses < 2) begin
        run_byte(rows[r].pulses == 1, rows[r].tx, rows[r].rx);
        check("oe a", {7'h00, rows[r].pulses == 0}, {7'h00, oe_a});
        check("oe b", {7'h00, rows[r].pulses == 1}, {7'h00, oe_b});
      end
      i_prog.leave();
      wait_mode(1'b0);
      check("link cleared", 8'h00, {6'h00, status.link});
      check("oe off", 8'h00, {6'h00, oe_a, oe_b});
      $display("row %0d done", r);
    end
    // Link clock far above the window must be flagged
    i_prog.enter(0);
    wait_mode(1'b1);
    i_prog.xfer(1'b0, 8'h55, 7.5, rx);
    for (n = 0; n < 200 && status.rate_error !== 1'b1; n++) @(negedge clk);
    check("fast clock flag", 8'h01, {7'h00, status.rate_error});
    if (n == 200) finish_test();
    $display("fast clock test done");
    // Reset in mid-mode clears everything
    @(negedge clk);
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check("mid reset status", 8'h00, {4'h0, status});
    i_prog.leave();
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (2) @(negedge clk);
    check("status after reset", 8'h00, {4'h0, status});
    $display("reset test done");
    finish_test();
  end
endmodule
`default_nettype wire
